// file: rtl/sctl_top.sv
`timescale 1ns/1ps
module sctl_top (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_op,
  input  wire logic [15:0] cmd_arg,
  input  wire logic [15:0] cmd_pc,
  input  wire logic [15:0] cmd_psw,
  input  wire logic [15:0] cmd_sp,
  output logic             busy,
  output logic             done,
  output logic [15:0]      program_counter_register,
  output logic [15:0]      processor_status_word,
  output logic [15:0]      stack_pointer_register,
  output logic [15:0]      eff_addr,
  output logic             eff_addr_valid,
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack
);
  sctl_pkg::sctl_state_t state_r;
  logic [15:0] pc_r;
  logic [15:0] psw_r;
  logic [15:0] sp_r;
  logic [15:0] vec_r;
  logic [15:0] tmp_r;
  logic [15:0] ea_r;
  logic        ea_valid_r;
  logic        busy_r;
  logic        done_r;
  logic        req_r;
  logic        we_r;
  logic [15:0] addr_r;
  logic [15:0] wdata_r;
  logic        accept;

  assign accept = cmd_valid && (state_r == sctl_pkg::ST_IDLE);

  // Pushes predecrement, pops read the current top
  function automatic logic [15:0] addr_f(sctl_pkg::sctl_state_t st,
                                         logic [15:0] sp,
                                         logic [15:0] vec);
    case (st)
      sctl_pkg::ST_PUSH_SW,
      sctl_pkg::ST_PUSH_PC,
      sctl_pkg::ST_CO_PUSH: addr_f = sp - sctl_pkg::WORD_STEP;
      sctl_pkg::ST_VEC_PC:  addr_f = vec;
      sctl_pkg::ST_VEC_SW:  addr_f = vec + sctl_pkg::WORD_STEP;
      default:              addr_f = sp;
    endcase
  endfunction : addr_f

  function automatic logic is_write_f(sctl_pkg::sctl_state_t st);
    is_write_f = (st == sctl_pkg::ST_PUSH_SW) ||
                 (st == sctl_pkg::ST_PUSH_PC) ||
                 (st == sctl_pkg::ST_CO_PUSH);
  endfunction : is_write_f

  // Sequencer; one idle cycle between memory cycles keeps the port simple
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= sctl_pkg::ST_IDLE;
      pc_r    <= sctl_pkg::PC_RST;
      psw_r   <= sctl_pkg::PSW_RST;
      sp_r    <= sctl_pkg::SP_RST;
      vec_r   <= 16'h0000;
      tmp_r   <= 16'h0000;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      addr_r  <= 16'h0000;
      wdata_r <= 16'h0000;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        sctl_pkg::ST_IDLE: begin
          if (accept) begin
            vec_r <= cmd_arg;
            case (cmd_op)
              sctl_pkg::OP_LOAD: begin
                pc_r   <= cmd_pc;
                psw_r  <= cmd_psw;
                sp_r   <= cmd_sp;
                done_r <= 1'b1;
              end
              sctl_pkg::OP_INTR: begin
                state_r <= sctl_pkg::ST_PUSH_SW;
                busy_r  <= 1'b1;
              end
              sctl_pkg::OP_IRET,
              sctl_pkg::OP_RTSPC: begin
                state_r <= sctl_pkg::ST_POP_PC;
                busy_r  <= 1'b1;
              end
              sctl_pkg::OP_CORTN: begin
                state_r <= sctl_pkg::ST_CO_POP;
                busy_r  <= 1'b1;
              end
              default: done_r <= 1'b1;
            endcase
            tmp_r <= {13'h0000, cmd_op};
          end
        end
        default: begin
          if (!req_r) begin
            req_r  <= 1'b1;
            addr_r <= addr_f(state_r, sp_r, vec_r);
            we_r   <= is_write_f(state_r);
            case (state_r)
              sctl_pkg::ST_PUSH_SW: wdata_r <= psw_r;
              sctl_pkg::ST_PUSH_PC,
              sctl_pkg::ST_CO_PUSH: wdata_r <= pc_r;
              default:              wdata_r <= 16'h0000;
            endcase
          end else if (mem_ack) begin
            req_r <= 1'b0;
            we_r  <= 1'b0;
            case (state_r)
              sctl_pkg::ST_PUSH_SW: begin
                sp_r    <= sp_r - sctl_pkg::WORD_STEP;
                state_r <= sctl_pkg::ST_PUSH_PC;
              end
              sctl_pkg::ST_PUSH_PC: begin
                sp_r    <= sp_r - sctl_pkg::WORD_STEP;
                state_r <= sctl_pkg::ST_VEC_PC;
              end
              sctl_pkg::ST_VEC_PC: begin
                pc_r    <= mem_rdata;
                state_r <= sctl_pkg::ST_VEC_SW;
              end
              sctl_pkg::ST_POP_PC: begin
                pc_r <= mem_rdata;
                sp_r <= sp_r + sctl_pkg::WORD_STEP;
                if (tmp_r[2:0] == sctl_pkg::OP_IRET) begin
                  state_r <= sctl_pkg::ST_POP_SW;
                end else begin
                  state_r <= sctl_pkg::ST_IDLE;
                  busy_r  <= 1'b0;
                  done_r  <= 1'b1;
                end
              end
              sctl_pkg::ST_POP_SW: begin
                psw_r   <= mem_rdata;
                sp_r    <= sp_r + sctl_pkg::WORD_STEP;
                state_r <= sctl_pkg::ST_IDLE;
                busy_r  <= 1'b0;
                done_r  <= 1'b1;
              end
              sctl_pkg::ST_CO_POP: begin
                tmp_r   <= mem_rdata;
                sp_r    <= sp_r + sctl_pkg::WORD_STEP;
                state_r <= sctl_pkg::ST_CO_PUSH;
              end
              sctl_pkg::ST_CO_PUSH: begin
                sp_r    <= sp_r - sctl_pkg::WORD_STEP;
                pc_r    <= tmp_r;
                state_r <= sctl_pkg::ST_IDLE;
                busy_r  <= 1'b0;
                done_r  <= 1'b1;
              end
              sctl_pkg::ST_VEC_SW: begin
                psw_r   <= mem_rdata;
                state_r <= sctl_pkg::ST_IDLE;
                busy_r  <= 1'b0;
                done_r  <= 1'b1;
              end
              default: begin
                state_r <= sctl_pkg::ST_IDLE;
                busy_r  <= 1'b0;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Offset wraps modulo 64K, as the address space does
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ea_r       <= 16'h0000;
      ea_valid_r <= 1'b0;
    end else begin
      ea_valid_r <= accept && (cmd_op == sctl_pkg::OP_PCREL);
      if (accept && (cmd_op == sctl_pkg::OP_PCREL)) begin
        ea_r <= pc_r + cmd_arg;
      end
    end
  end

  assign busy                     = busy_r;
  assign done                     = done_r;
  assign program_counter_register = pc_r;
  assign processor_status_word    = psw_r;
  assign stack_pointer_register   = sp_r;
  assign eff_addr                 = ea_r;
  assign eff_addr_valid           = ea_valid_r;
  assign mem_req                  = req_r;
  assign mem_we                   = we_r;
  assign mem_addr                 = addr_r;
  assign mem_wdata                = wdata_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_done_in(sctl_pkg::sctl_state_t st);
    state_r == st && req_r && mem_ack;
  endsequence

  a_intr_start: assert property (accept && cmd_op == sctl_pkg::OP_INTR
    |=> state_r == sctl_pkg::ST_PUSH_SW ##1 req_r && we_r)
    else $error("interrupt entry did not start a push");
  a_psw_push: assert property (state_r == sctl_pkg::ST_PUSH_SW && req_r
    |-> we_r && wdata_r == psw_r && addr_r == sp_r - 16'h0002)
    else $error("status push wrong");
  a_pc_after_sw: assert property (s_done_in(sctl_pkg::ST_PUSH_SW)
    |=> state_r == sctl_pkg::ST_PUSH_PC ##1 wdata_r == pc_r)
    else $error("pc push did not follow status push");
  a_vec_load: assert property (s_done_in(sctl_pkg::ST_VEC_PC)
    |=> pc_r == $past(mem_rdata) && state_r == sctl_pkg::ST_VEC_SW
    ##1 addr_r == vec_r + 16'h0002)
    else $error("vector pc load wrong");
  a_iret_psw: assert property (s_done_in(sctl_pkg::ST_POP_SW)
    |=> psw_r == $past(mem_rdata) && sp_r == $past(sp_r) + 16'h0002
    && done_r)
    else $error("status restore wrong");
  a_rts_pc: assert property (s_done_in(sctl_pkg::ST_POP_PC)
    |=> pc_r == $past(mem_rdata))
    else $error("return pc wrong");
  a_co_pop: assert property (s_done_in(sctl_pkg::ST_CO_POP)
    |=> tmp_r == $past(mem_rdata) && sp_r == $past(sp_r) + 16'h0002)
    else $error("co-routine pop wrong");
  a_co_push: assert property (state_r == sctl_pkg::ST_CO_PUSH && req_r
    |-> we_r && wdata_r == pc_r && addr_r == sp_r - 16'h0002)
    else $error("co-routine push wrong");
  a_co_jump: assert property (s_done_in(sctl_pkg::ST_CO_PUSH)
    |=> pc_r == $past(tmp_r) && !busy_r)
    else $error("co-routine jump wrong");
  a_pcrel_sum: assert property (accept && cmd_op == sctl_pkg::OP_PCREL
    |=> ea_valid_r && ea_r == $past(pc_r) + $past(cmd_arg))
    else $error("pc-relative address wrong");
  a_sp_step: assert property ($changed(sp_r) && !$past(accept)
    |-> sp_r == $past(sp_r) + 16'h0002
     || sp_r == $past(sp_r) - 16'h0002)
    else $error("stack pointer step not two");
endmodule : sctl_top

// file: rtl/sctl_pkg.sv
package sctl_pkg;
  localparam int          WORD_W    = 16;
  localparam int          OP_W      = 3;
  // One word is two byte addresses
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [15:0] PSW_RST   = 16'h0000;
  localparam logic [15:0] SP_RST    = 16'h0000;

  localparam logic [2:0] OP_LOAD  = 3'h0;
  localparam logic [2:0] OP_INTR  = 3'h1;
  localparam logic [2:0] OP_IRET  = 3'h2;
  localparam logic [2:0] OP_RTSPC = 3'h3;
  localparam logic [2:0] OP_CORTN = 3'h4;
  localparam logic [2:0] OP_PCREL = 3'h5;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_PUSH_SW = 4'h1,
    ST_PUSH_PC = 4'h2,
    ST_VEC_PC  = 4'h3,
    ST_VEC_SW  = 4'h4,
    ST_POP_PC  = 4'h5,
    ST_POP_SW  = 4'h6,
    ST_CO_POP  = 4'h7,
    ST_CO_PUSH = 4'h8
  } sctl_state_t;
endpackage : sctl_pkg

// file: sim/sctl_mem_model.sv
`timescale 1ns/1ps
module sctl_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [3:0]  delay,
  output logic [15:0]      mem_rdata,
  output logic             mem_ack
);
  logic [15:0] mem [0:255];
  logic [3:0]  wait_r;
  logic        tog_r;

  // Wait states let the bench test slow memory too
  always_ff @(posedge ref_clk) begin
    if (rst || !mem_req || mem_ack) wait_r <= 4'h0;
    else wait_r <= wait_r + 4'h1;
  end

  // Reset so the idle bus toggles instead of staying unknown
  always_ff @(posedge ref_clk) begin
    if (rst) tog_r <= 1'b0;
    else tog_r <= ~tog_r;
  end

  assign mem_ack = mem_req && !rst && (wait_r == delay);
  // Bus shows garbage outside a read ack, never stale data
  assign mem_rdata = (mem_ack && !mem_we) ? mem[mem_addr[8:1]]
                                          : ({16{tog_r}} ^ 16'h5a5a);

  always @(posedge ref_clk) begin
    if (mem_ack && mem_we) mem[mem_addr[8:1]] <= mem_wdata;
  end
endmodule : sctl_mem_model

// file: sim/test_stack_control_transfer.sv
`timescale 1ns/1ps
module test_stack_control_transfer;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic [2:0]  cmd_op = 3'h0;
  logic [15:0] cmd_arg = 16'h0000;
  logic [15:0] cmd_pc = 16'h0000;
  logic [15:0] cmd_psw = 16'h0000;
  logic [15:0] cmd_sp = 16'h0000;
  logic [3:0]  delay = 4'h0;
  logic        busy, done, eff_addr_valid, mem_req, mem_we, mem_ack;
  logic [15:0] pc, psw, sp, eff_addr, mem_addr, mem_wdata, mem_rdata;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cycles = 0;
  logic        busy_seen = 1'b0;

  always #20 ref_clk = ~ref_clk;

  sctl_top u_dut (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_arg(cmd_arg), .cmd_pc(cmd_pc),
    .cmd_psw(cmd_psw), .cmd_sp(cmd_sp), .busy(busy), .done(done),
    .program_counter_register(pc), .processor_status_word(psw),
    .stack_pointer_register(sp), .eff_addr(eff_addr),
    .eff_addr_valid(eff_addr_valid), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));

  sctl_mem_model u_mem (.ref_clk(ref_clk), .rst(rst), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .delay(delay), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  task automatic conclude;
    $display("counts: checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One pulse of cmd_valid, then wait for done or eff_addr_valid
  task automatic cmd(input logic [2:0] op, input logic [15:0] arg);
    int i;
    busy_seen = 1'b0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_arg   <= arg;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 200; i++) begin
      #1;
      if (busy === 1'b1) busy_seen = 1'b1;
      if (done === 1'b1 || eff_addr_valid === 1'b1) break;
      @(posedge ref_clk);
    end
    chk({15'h0000, (done === 1'b1 || eff_addr_valid === 1'b1)}, 16'h0001);
  endtask : cmd

  task automatic t_load_pcrel;
    cmd_pc  <= 16'h1000;
    cmd_psw <= 16'h00e0;
    cmd_sp  <= 16'h0100;
    cmd(sctl_pkg::OP_LOAD, 16'h0000);
    chk(pc, 16'h1000);
    chk(sp, 16'h0100);
    chk(psw, 16'h00e0);
    // Unused op codes only pulse done
    cmd(3'h6, 16'h0000);
    chk(pc, 16'h1000);
    chk(sp, 16'h0100);
    cmd(sctl_pkg::OP_PCREL, 16'h0010);
    chk(eff_addr, 16'h1010);
    cmd(sctl_pkg::OP_PCREL, 16'hfff0);
    chk(eff_addr, 16'h0ff0);
    $display("test load_pcrel done");
  endtask : t_load_pcrel

  // Slow memory: three wait states on every access
  task automatic t_intr;
    delay <= 4'h3;
    u_mem.mem[8'h20] = 16'h2000;
    u_mem.mem[8'h21] = 16'h00c0;
    cmd(sctl_pkg::OP_INTR, 16'h0040);
    chk(u_mem.mem[8'h7f], 16'h00e0);
    chk(u_mem.mem[8'h7e], 16'h1000);
    chk(sp, 16'h00fc);
    chk(pc, 16'h2000);
    chk(psw, 16'h00c0);
    chk({15'h0000, busy_seen}, 16'h0001);
    chk({15'h0000, busy}, 16'h0000);
    $display("test intr done");
  endtask : t_intr

  task automatic t_coroutine;
    delay <= 4'h0;
    cmd(sctl_pkg::OP_CORTN, 16'h0000);
    chk(pc, 16'h1000);
    chk(u_mem.mem[8'h7e], 16'h2000);
    chk(sp, 16'h00fc);
    cmd(sctl_pkg::OP_CORTN, 16'h0000);
    chk(pc, 16'h2000);
    chk(u_mem.mem[8'h7e], 16'h1000);
    $display("test coroutine done");
  endtask : t_coroutine

  task automatic t_returns;
    delay <= 4'h1;
    u_mem.mem[8'h80] = 16'h4444;
    cmd(sctl_pkg::OP_IRET, 16'h0000);
    chk(pc, 16'h1000);
    chk(psw, 16'h00e0);
    chk(sp, 16'h0100);
    cmd(sctl_pkg::OP_RTSPC, 16'h0000);
    chk(pc, 16'h4444);
    chk(sp, 16'h0102);
    $display("test returns done");
  endtask : t_returns

  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_load_pcrel();
    t_intr();
    t_coroutine();
    t_returns();
    conclude();
  end
endmodule : test_stack_control_transfer
